//--- design/pcs_addr_decode.sv
// decodes an 18-bit address into target kind, quad and channel masks
`timescale 1ns/1ns
module pcs_addr_decode (
  pcs_dec_if.dec d
);
  always_comb begin
    d.kind      = pcs_regmap_pkg::T_NONE;
    d.quad_mask = 8'h00;
    d.chan_mask = 4'h0;
    d.rd_quad   = 3'h0;
    d.rd_chan   = 2'h0;
    d.offset    = d.addr[7:0];
    if (d.addr[17:8] == pcs_regmap_pkg::PAGE_INTERQUAD) begin
      d.kind = pcs_regmap_pkg::T_INTERQUAD;
    end else if (d.addr[17:10] == pcs_regmap_pkg::PAGE_QUAD_L ||
                 d.addr[17:10] == pcs_regmap_pkg::PAGE_QUAD_R) begin
      d.kind    = pcs_regmap_pkg::T_QUAD;
      d.rd_quad = {d.addr[15], d.addr[9:8]};
      d.quad_mask[{d.addr[15], d.addr[9:8]}] = 1'b1;
    end else if (d.addr[17:8] == pcs_regmap_pkg::PAGE_QUAD_BC_L ||
                 d.addr[17:8] == pcs_regmap_pkg::PAGE_QUAD_BC_R) begin
      d.kind      = pcs_regmap_pkg::T_QUAD;
      d.rd_quad   = {d.addr[15], 2'h0};
      d.quad_mask = d.addr[15] ? 8'hF0 : 8'h0F;
    end else if (d.addr[17:12] == pcs_regmap_pkg::PAGE_CHAN_L ||
                 d.addr[17:12] == pcs_regmap_pkg::PAGE_CHAN_R) begin
      d.kind    = pcs_regmap_pkg::T_CHAN;
      d.rd_quad = {d.addr[15], d.addr[11:10]};
      d.rd_chan = d.addr[9:8];
      d.quad_mask[{d.addr[15], d.addr[11:10]}] = 1'b1;
      d.chan_mask[d.addr[9:8]] = 1'b1;
    end else if ((d.addr[17:14] == pcs_regmap_pkg::PAGE_BC4_L ||
                  d.addr[17:14] == pcs_regmap_pkg::PAGE_BC4_R) && d.addr[11:8] == 4'h0) begin
      d.kind      = pcs_regmap_pkg::T_CHAN;
      d.rd_quad   = {d.addr[15], d.addr[13:12]};
      d.quad_mask[{d.addr[15], d.addr[13:12]}] = 1'b1;
      d.chan_mask = 4'hF;
    end else if (d.addr[17:8] == pcs_regmap_pkg::PAGE_SIDE_BC_L ||
                 d.addr[17:8] == pcs_regmap_pkg::PAGE_SIDE_BC_R) begin
      d.kind      = pcs_regmap_pkg::T_CHAN;
      d.rd_quad   = {d.addr[15], 2'h0};
      d.quad_mask = d.addr[15] ? 8'hF0 : 8'h0F;
      d.chan_mask = 4'hF;
    end
  end
endmodule : pcs_addr_decode

//--- design/pcs_dec_if.sv
// carrier between the address decoder and the register bank
`timescale 1ns/1ns
interface pcs_dec_if;
  logic [17:0]              addr;
  pcs_regmap_pkg::target_t  kind;
  logic [7:0]               quad_mask;
  logic [3:0]               chan_mask;
  logic [2:0]               rd_quad;
  logic [1:0]               rd_chan;
  logic [7:0]               offset;
  modport dec  (input addr, output kind, quad_mask, chan_mask, rd_quad, rd_chan, offset);
  modport user (output addr, input kind, quad_mask, chan_mask, rd_quad, rd_chan, offset);
endinterface : pcs_dec_if

//--- design/pcs_register_address_map.sv
// register bank behind the system bus for all quads and channels
`timescale 1ns/1ns
module pcs_register_address_map (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // system bus register port
  input  wire logic [17:0]  bus_addr,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  input  wire logic [7:0]   bus_wdata,
  output logic      [7:0]   bus_rdata,
  output logic              bus_ack,
  // configuration load port
  input  wire logic         cfg_we,
  input  wire logic [17:0]  cfg_addr,
  input  wire logic [7:0]   cfg_wdata,
  // status from quads and channels
  input  wire logic [7:0]   align23_in,
  input  wire logic [31:0]  ctc_urun_in,
  input  wire logic [31:0]  ctc_orun_in,
  input  wire logic [7:0]   quad_rst_in,
  // control to quads
  output logic [63:0]       quad_mode,
  output logic [7:0]        quad_four_align,
  output logic [7:0]        interquad_ctl
);
  pcs_dec_if dif ();

  // synchronisers
  logic [7:0]  al_s1_r, al_s2_r;
  logic [31:0] ur_s1_r, ur_s2_r;
  logic [31:0] or_s1_r, or_s2_r;
  logic [7:0]  qr_s1_r, qr_s2_r;

  // register state
  logic [7:0] q_int_en_r [8];
  logic [7:0] q_int_en_nxt [8];
  logic [7:0] q_mode_r [8];
  logic [7:0] q_mode_nxt [8];
  logic [7:0] q_align_r [8];
  logic [7:0] q_align_nxt [8];
  logic [7:0] q_rst_r [8];
  logic [7:0] q_rst_nxt [8];
  logic [7:0] c_int_en_r [32];
  logic [7:0] c_int_en_nxt [32];
  logic [7:0] interquad_ctl_r;
  logic [7:0] interquad_ctl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       ack_r;
  logic       ack_nxt;
  logic [63:0] quad_mode_r;
  logic [63:0] quad_mode_nxt;
  logic [7:0]  four_r;
  logic [7:0]  four_nxt;

  // access select
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  qclr;
  logic [63:0] cclr;

  // flags
  logic [7:0]  q_flag_st, q_flag_en, q_flag_rc, q_flags;
  logic [63:0] c_flag_st, c_flag_en, c_flag_rc, c_flags;

  // bus has priority; config writes land only when the bus is idle
  always_comb begin
    wr = bus_wr | (cfg_we & ~bus_rd);
    rd = bus_rd & ~bus_wr;
    wdata = (bus_wr | bus_rd) ? bus_wdata : cfg_wdata;
    dif.addr = (bus_wr | bus_rd) ? bus_addr : cfg_addr;
  end

  pcs_addr_decode u_dec (
    .d (dif.dec)
  );

  // quad reset from pin or control bit clears quad and its channels
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      qclr[q] = qr_s2_r[q] | q_rst_r[q][pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_QUAD_RST)];
    end
    for (int i = 0; i < 64; i++) begin
      cclr[i] = qclr[i / 8];
    end
  end

  // flag sources
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      // inactive while the quad aligns all four channels together
      q_flag_st[q] = al_s2_r[q] &
                     ~q_align_r[q][pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_FOUR_ALIGN)];
      q_flag_en[q] = q_int_en_r[q][pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_ALIGN23)];
      q_flag_rc[q] = rd && dif.kind == pcs_regmap_pkg::T_QUAD && dif.rd_quad == 3'(q) &&
                     dif.offset == pcs_regmap_pkg::OFF_QUAD_FLAGS;
    end
    for (int c = 0; c < 32; c++) begin
      c_flag_st[2*c]   = ur_s2_r[c];
      c_flag_st[2*c+1] = or_s2_r[c];
      c_flag_en[2*c]   = c_int_en_r[c][pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_URUN)];
      c_flag_en[2*c+1] = c_int_en_r[c][pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_ORUN)];
      c_flag_rc[2*c]   = rd && dif.kind == pcs_regmap_pkg::T_CHAN &&
                         {dif.rd_quad, dif.rd_chan} == 5'(c) &&
                         dif.offset == pcs_regmap_pkg::OFF_CHAN_FLAGS;
      c_flag_rc[2*c+1] = c_flag_rc[2*c];
    end
  end

  pcs_sticky_flags #(.N(8)) u_qflags (
    .core_clk (core_clk),
    .rst      (rst),
    .status   (q_flag_st),
    .enable   (q_flag_en),
    .read_clr (q_flag_rc),
    .hw_clr   (qclr),
    .flags    (q_flags)
  );

  pcs_sticky_flags #(.N(64)) u_cflags (
    .core_clk (core_clk),
    .rst      (rst),
    .status   (c_flag_st),
    .enable   (c_flag_en),
    .read_clr (c_flag_rc),
    .hw_clr   (cclr),
    .flags    (c_flags)
  );

  // register writes
  always_comb begin
    interquad_ctl_nxt = interquad_ctl_r;
    if (wr && dif.kind == pcs_regmap_pkg::T_INTERQUAD &&
        dif.offset == pcs_regmap_pkg::OFF_INTERQUAD_CTL) begin
      interquad_ctl_nxt = wdata;
    end
    for (int q = 0; q < 8; q++) begin
      q_int_en_nxt[q] = q_int_en_r[q];
      q_mode_nxt[q]   = q_mode_r[q];
      q_align_nxt[q]  = q_align_r[q];
      q_rst_nxt[q]    = q_rst_r[q];
      if (qclr[q]) begin
        q_int_en_nxt[q] = pcs_regmap_pkg::RST_BYTE;
        q_mode_nxt[q]   = pcs_regmap_pkg::RST_BYTE;
        q_align_nxt[q]  = pcs_regmap_pkg::RST_BYTE;
        q_rst_nxt[q]    = pcs_regmap_pkg::RST_BYTE;
      end else if (wr && dif.kind == pcs_regmap_pkg::T_QUAD && dif.quad_mask[q]) begin
        unique case (dif.offset)
          pcs_regmap_pkg::OFF_QUAD_INT_EN: q_int_en_nxt[q] = wdata;
          pcs_regmap_pkg::OFF_QUAD_MODE:   q_mode_nxt[q]   = wdata;
          pcs_regmap_pkg::OFF_QUAD_ALIGN:  q_align_nxt[q]  = wdata;
          pcs_regmap_pkg::OFF_QUAD_RST:    q_rst_nxt[q]    = wdata;
          default: ;
        endcase
      end
    end
    for (int c = 0; c < 32; c++) begin
      c_int_en_nxt[c] = c_int_en_r[c];
      if (qclr[c / 4]) begin
        c_int_en_nxt[c] = pcs_regmap_pkg::RST_BYTE;
      end else if (wr && dif.kind == pcs_regmap_pkg::T_CHAN && dif.quad_mask[c / 4] &&
                   dif.chan_mask[c % 4] && dif.offset == pcs_regmap_pkg::OFF_CHAN_INT_EN) begin
        c_int_en_nxt[c] = wdata;
      end
    end
  end

  // read data, broadcast groups answer from their first member
  always_comb begin
    logic [2:0] rq;
    logic [4:0] rc;
    rq = dif.rd_quad;
    rc = {dif.rd_quad, dif.rd_chan};
    rdata_nxt = rdata_r;
    ack_nxt   = bus_wr | bus_rd;
    if (rd) begin
      rdata_nxt = pcs_regmap_pkg::RST_UNMAPPED;
      unique case (dif.kind)
        pcs_regmap_pkg::T_INTERQUAD: begin
          if (dif.offset == pcs_regmap_pkg::OFF_INTERQUAD_CTL) rdata_nxt = interquad_ctl_r;
        end
        pcs_regmap_pkg::T_QUAD: begin
          unique case (dif.offset)
            pcs_regmap_pkg::OFF_QUAD_INT_EN: rdata_nxt = q_int_en_r[rq];
            pcs_regmap_pkg::OFF_QUAD_MODE:   rdata_nxt = q_mode_r[rq];
            pcs_regmap_pkg::OFF_QUAD_ALIGN:  rdata_nxt = q_align_r[rq];
            pcs_regmap_pkg::OFF_QUAD_RST:    rdata_nxt = q_rst_r[rq];
            pcs_regmap_pkg::OFF_QUAD_STATUS:
              rdata_nxt[pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_ALIGN23)] = q_flag_st[rq];
            pcs_regmap_pkg::OFF_QUAD_FLAGS:
              rdata_nxt[pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_ALIGN23)] = q_flags[rq];
            default: ;
          endcase
        end
        pcs_regmap_pkg::T_CHAN: begin
          unique case (dif.offset)
            pcs_regmap_pkg::OFF_CHAN_INT_EN: rdata_nxt = c_int_en_r[rc];
            pcs_regmap_pkg::OFF_CHAN_STATUS: begin
              rdata_nxt[pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_URUN)] = ur_s2_r[rc];
              rdata_nxt[pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_ORUN)] = or_s2_r[rc];
            end
            pcs_regmap_pkg::OFF_CHAN_FLAGS: begin
              rdata_nxt[pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_URUN)] = c_flags[{rc, 1'b0}];
              rdata_nxt[pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_ORUN)] = c_flags[{rc, 1'b1}];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // per-quad control outputs
  always_comb begin
    for (int q = 0; q < 8; q++) begin
      quad_mode_nxt[8*q +: 8] = q_mode_nxt[q];
      four_nxt[q] = q_align_nxt[q][pcs_regmap_pkg::be(pcs_regmap_pkg::BIT_FOUR_ALIGN)];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      al_s1_r <= '0;
      al_s2_r <= '0;
      ur_s1_r <= '0;
      ur_s2_r <= '0;
      or_s1_r <= '0;
      or_s2_r <= '0;
      qr_s1_r <= '0;
      qr_s2_r <= '0;
      for (int q = 0; q < 8; q++) begin
        q_int_en_r[q] <= pcs_regmap_pkg::RST_BYTE;
        q_mode_r[q]   <= pcs_regmap_pkg::RST_BYTE;
        q_align_r[q]  <= pcs_regmap_pkg::RST_BYTE;
        q_rst_r[q]    <= pcs_regmap_pkg::RST_BYTE;
      end
      for (int c = 0; c < 32; c++) begin
        c_int_en_r[c] <= pcs_regmap_pkg::RST_BYTE;
      end
      interquad_ctl_r <= pcs_regmap_pkg::RST_BYTE;
      rdata_r     <= pcs_regmap_pkg::RST_BYTE;
      ack_r       <= 1'b0;
      quad_mode_r <= '0;
      four_r      <= '0;
    end else begin
      al_s1_r <= align23_in;
      al_s2_r <= al_s1_r;
      ur_s1_r <= ctc_urun_in;
      ur_s2_r <= ur_s1_r;
      or_s1_r <= ctc_orun_in;
      or_s2_r <= or_s1_r;
      qr_s1_r <= quad_rst_in;
      qr_s2_r <= qr_s1_r;
      q_int_en_r  <= q_int_en_nxt;
      q_mode_r    <= q_mode_nxt;
      q_align_r   <= q_align_nxt;
      q_rst_r     <= q_rst_nxt;
      c_int_en_r  <= c_int_en_nxt;
      interquad_ctl_r <= interquad_ctl_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
      quad_mode_r <= quad_mode_nxt;
      four_r      <= four_nxt;
    end
  end

  assign bus_rdata       = rdata_r;
  assign bus_ack         = ack_r;
  assign quad_mode       = quad_mode_r;
  assign quad_four_align = four_r;
  assign interquad_ctl   = interquad_ctl_r;
endmodule : pcs_register_address_map

//--- design/pcs_regmap_pkg.sv
// shared constants and types for the transceiver register address map
package pcs_regmap_pkg;
  localparam int NUM_QUADS = 8;
  localparam int NUM_CHANS = 4;
  localparam int NUM_CH_TOTAL = 32;
  // address pages (address bits 17:8 unless noted)
  localparam logic [9:0] PAGE_INTERQUAD   = 10'h3EF;
  localparam logic [7:0] PAGE_QUAD_L      = 8'hD8;   // bits 17:10 of 36000-363FF
  localparam logic [7:0] PAGE_QUAD_R      = 8'hF8;   // bits 17:10 of 3E000-3E3FF
  localparam logic [9:0] PAGE_QUAD_BC_L   = 10'h364;
  localparam logic [9:0] PAGE_QUAD_BC_R   = 10'h3E4;
  localparam logic [5:0] PAGE_CHAN_L      = 6'h35;   // bits 17:12
  localparam logic [5:0] PAGE_CHAN_R      = 6'h3D;
  localparam logic [3:0] PAGE_BC4_L       = 4'hC;    // bits 17:14 of 30000-33FFF
  localparam logic [3:0] PAGE_BC4_R       = 4'hE;    // bits 17:14 of 38000-3BFFF
  localparam logic [9:0] PAGE_SIDE_BC_L   = 10'h340;
  localparam logic [9:0] PAGE_SIDE_BC_R   = 10'h3C0;
  // register offsets
  localparam logic [7:0] OFF_INTERQUAD_CTL = 8'h00;
  localparam logic [7:0] OFF_CHAN_INT_EN  = 8'h0A;
  localparam logic [7:0] OFF_CHAN_STATUS  = 8'h85;
  localparam logic [7:0] OFF_CHAN_FLAGS   = 8'h8A;
  localparam logic [7:0] OFF_QUAD_INT_EN  = 8'h0C;
  localparam logic [7:0] OFF_QUAD_STATUS  = 8'h82;
  localparam logic [7:0] OFF_QUAD_FLAGS   = 8'h83;
  localparam logic [7:0] OFF_QUAD_MODE    = 8'h18;
  localparam logic [7:0] OFF_QUAD_ALIGN   = 8'h19;
  localparam logic [7:0] OFF_QUAD_RST     = 8'h43;
  // field positions, msb-first numbering
  localparam int BIT_ALIGN23     = 3;
  localparam int BIT_URUN        = 6;
  localparam int BIT_ORUN        = 7;
  localparam int BIT_QUAD_RST    = 7;
  localparam int BIT_FOUR_ALIGN  = 1;
  // reset values
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [7:0] RST_UNMAPPED    = 8'h00;

  typedef enum {T_NONE, T_INTERQUAD, T_QUAD, T_CHAN} target_t;

  // msb-first bit number to lsb-first index
  function automatic int be(input int n);
    be = 7 - n;
  endfunction : be
endpackage : pcs_regmap_pkg

//--- design/pcs_sticky_flags.sv
// bank of sticky interrupt bits, set while enabled status is high, cleared on read
`timescale 1ns/1ns
module pcs_sticky_flags #(
  parameter int N = 8
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // control
  input  wire logic [N-1:0]  status,
  input  wire logic [N-1:0]  enable,
  input  wire logic [N-1:0]  read_clr,
  input  wire logic [N-1:0]  hw_clr,
  // result
  output logic      [N-1:0]  flags
);
  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;

  always_comb begin
    // set wins over a read clear in the same cycle
    flags_nxt = ((flags_r & ~read_clr) | (status & enable)) & ~hw_clr;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
endmodule : pcs_sticky_flags

//--- verif/pcs_bus_master.sv
// system bus master model issuing byte register accesses
`timescale 1ns/1ns
module pcs_bus_master (
  // clock
  input  wire logic        core_clk,
  // bus toward the register map
  output logic      [17:0] bus_addr,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [7:0]  bus_wdata,
  input  wire logic        bus_ack,
  input  wire logic [7:0]  bus_rdata
);
  initial begin
    bus_addr = 18'h00000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end

  // one strobe per access, address held until ack; power-up is never broadcast
  task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= w ? d : ~bus_wdata; // byte wide, msb-first bit 0
    bus_wr <= w;
    bus_rd <= !w;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (bus_ack !== 1'b1 && n < 4);
    q = bus_rdata;
    bus_wdata <= ~bus_wdata;
    if (bus_ack !== 1'b1) begin
      pcs_register_address_map_tb.failures++;
      $display("Error at %0t: no ack", $time);
      pcs_register_address_map_tb.give_verdict();
    end
  endtask : xfer
endmodule : pcs_bus_master

//--- verif/pcs_register_address_map_tb.sv
// bench for the register address map
`timescale 1ns/1ns
module pcs_register_address_map_tb;
  logic        core_clk, rst, bus_wr, bus_rd, bus_ack, cfg_we;
  logic [17:0] bus_addr, cfg_addr;
  logic [7:0]  bus_wdata, bus_rdata, cfg_wdata, align23_in, quad_rst_in, quad_four_align, interquad_ctl;
  logic [31:0] ctc_urun_in, ctc_orun_in;
  logic [63:0] quad_mode;
  int          failures = 0;
  int          total_checks = 0;

  pcs_register_address_map pcs_register_address_map_inst (.core_clk, .rst, .bus_addr, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .bus_ack, .cfg_we, .cfg_addr, .cfg_wdata, .align23_in, .ctc_urun_in,
    .ctc_orun_in, .quad_rst_in, .quad_mode, .quad_four_align, .interquad_ctl);
  pcs_bus_master pcs_bus_master_inst (.core_clk, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_ack,
    .bus_rdata);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    pcs_bus_master_inst.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [17:0] a, input logic [7:0] e);
    logic [7:0] q;
    pcs_bus_master_inst.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rdc
  task automatic done(input string s);
    $display("test %s done, %0d checks", s, total_checks);
  endtask : done
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  function automatic logic [17:0] qa(input int q);
    return q < 4 ? 18'(18'h36000 + q * 18'h100) : 18'(18'h3E000 + (q - 4) * 18'h100);
  endfunction : qa
  function automatic logic [17:0] ba(input int q);
    return q < 4 ? 18'(18'h30000 + q * 18'h1000) : 18'(18'h38000 + (q - 4) * 18'h1000);
  endfunction : ba
  function automatic logic [17:0] ca(input int ch);
    return 18'((ch < 16 ? 18'h35000 : 18'h3D000 - 18'h1000) + ch / 4 * 18'h400 + ch % 4 * 18'h100);
  endfunction : ca

  initial begin
    rst = 1'b1;
    cfg_we = 1'b0;
    cfg_addr = 18'h00000;
    cfg_wdata = 8'h00;
    align23_in = 8'h00;
    quad_rst_in = 8'h00;
    ctc_urun_in = 32'h00000000;
    ctc_orun_in = 32'h00000000;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    chk(interquad_ctl, 8'h00);
    rdc(qa(7) + 18'h18, 8'h00);
    wr(18'h3EF00, 8'hA5);
    rdc(18'h3EF00, 8'hA5);
    cfg_we <= 1'b1;
    cfg_addr <= 18'h3EF00;
    cfg_wdata <= 8'h5A;
    @(posedge core_clk);
    cfg_we <= 1'b0;
    @(posedge core_clk);
    chk(interquad_ctl, 8'h5A);
    done("inter-quad");
    for (int q = 0; q < 8; q++) wr(qa(q) + 18'h18, 8'(8'h10 + q));
    for (int q = 0; q < 8; q++) begin
      chk(quad_mode[8*q+:8], 8'(8'h10 + q));
      rdc(qa(q) + 18'h18, 8'(8'h10 + q));
    end
    wr(18'h36418, 8'h3C);
    wr(18'h3E418, 8'hC3);
    for (int q = 0; q < 8; q++) chk(quad_mode[8*q+:8], q < 4 ? 8'h3C : 8'hC3);
    wr(qa(2) + 18'h19, 8'h40);
    chk(quad_four_align, 8'h04);
    wr(qa(2) + 18'h19, 8'hBF);
    chk(quad_four_align, 8'h00);
    done("quad");
    for (int ch = 0; ch < 32; ch++) begin
      wr(ca(ch) + 18'h0A, 8'h03);
      rdc(ca(ch) + 18'h0A, 8'h03);
      rdc(ca((ch + 1) % 32) + 18'h0A, 8'h00);
      wr(ca(ch) + 18'h0A, 8'h00);
    end
    for (int q = 0; q < 8; q++) begin
      wr(ba(q) + 18'h0A, 8'h02);
      for (int c = 0; c < 4; c++) rdc(ca(4 * q + c) + 18'h0A, 8'h02);
      rdc(ca((4 * q + 4) % 32) + 18'h0A, 8'h00);
      rdc(ba(q) + 18'h0A, 8'h02);
      wr(ba(q) + 18'h0A, 8'h00);
    end
    wr(18'h3400A, 8'h03);
    wr(18'h3C00A, 8'h01);
    rdc(ca(0) + 18'h0A, 8'h03);
    rdc(ca(15) + 18'h0A, 8'h03);
    rdc(ca(16) + 18'h0A, 8'h01);
    rdc(ca(31) + 18'h0A, 8'h01);
    done("channel");
    ctc_urun_in[5] <= 1'b1;
    repeat (4) @(posedge core_clk);
    ctc_urun_in[5] <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdc(ca(5) + 18'h85, 8'h00);
    rdc(ca(5) + 18'h8A, 8'h02);
    rdc(ca(5) + 18'h8A, 8'h00);
    ctc_orun_in[5] <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(ca(5) + 18'h85, 8'h01);
    rdc(ca(5) + 18'h8A, 8'h01);
    ctc_orun_in[5] <= 1'b0;
    rdc(ca(5) + 18'h8A, 8'h01);
    repeat (4) @(posedge core_clk);
    rdc(ca(5) + 18'h8A, 8'h01);
    rdc(ca(5) + 18'h8A, 8'h00);
    ctc_urun_in[20] <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(ca(20) + 18'h85, 8'h02);
    rdc(ca(20) + 18'h8A, 8'h00);
    ctc_urun_in[20] <= 1'b0;
    wr(qa(2) + 18'h0C, 8'h10);
    align23_in[2] <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(qa(2) + 18'h82, 8'h10);
    align23_in[2] <= 1'b0;
    repeat (4) @(posedge core_clk);
    rdc(qa(2) + 18'h83, 8'h10);
    rdc(qa(2) + 18'h83, 8'h00);
    wr(qa(2) + 18'h19, 8'h40);
    align23_in[2] <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(qa(2) + 18'h82, 8'h00);
    rdc(qa(2) + 18'h83, 8'h00);
    done("sticky");
    rdc(18'h20000, 8'h00);
    wr(18'h20018, 8'hFF);
    chk(quad_mode[7:0], 8'h3C);
    wr(qa(1) + 18'h43, 8'h01);
    @(posedge core_clk);
    chk(quad_mode[15:8], 8'h00);
    rdc(qa(1) + 18'h43, 8'h00);
    rdc(ca(4) + 18'h0A, 8'h00);
    quad_rst_in[2] <= 1'b1;
    repeat (4) @(posedge core_clk);
    quad_rst_in[2] <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(quad_four_align, 8'h00);
    rdc(qa(2) + 18'h0C, 8'h00);
    rdc(ca(8) + 18'h0A, 8'h00);
    rdc(ca(12) + 18'h0A, 8'h03);
    done("reset");
    give_verdict();
  end
endmodule : pcs_register_address_map_tb

//--- verif/pcs_regmap_properties.sv
// checker watching the register map ports
`timescale 1ns/1ns
module pcs_regmap_properties (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // system bus
  input wire logic [17:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_ack,
  // configuration load
  input wire logic        cfg_we,
  input wire logic [17:0] cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  // status and control
  input wire logic [7:0]  align23_in,
  input wire logic [31:0] ctc_urun_in,
  input wire logic [31:0] ctc_orun_in,
  input wire logic [7:0]  quad_rst_in,
  input wire logic [63:0] quad_mode,
  input wire logic [7:0]  quad_four_align,
  input wire logic [7:0]  interquad_ctl
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence qrst_held;
    quad_rst_in[2] [*3];
  endsequence

  ack_follows_a: assert property (1'b1 |-> bus_ack == $past(bus_wr | bus_rd))
    else $error("ack not one cycle after access");
  rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (bus_rd && !bus_wr && bus_addr == 18'h20000 |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  interquad_write_a: assert property (bus_wr && bus_addr == 18'h3EF00 |=> interquad_ctl == $past(bus_wdata))
    else $error("inter-quad write lost");
  cfg_load_a: assert property (cfg_we && !bus_wr && !bus_rd && cfg_addr == 18'h3EF00
    |=> interquad_ctl == $past(cfg_wdata))
    else $error("config load lost");
  mode_write_a: assert property (bus_wr && bus_addr == 18'h36018 && quad_rst_in == 8'h00
    |=> quad_mode[7:0] == $past(bus_wdata))
    else $error("quad mode write lost");
  quad_bcast_a: assert property (bus_wr && bus_addr == 18'h3E418 && quad_rst_in == 8'h00
    |=> quad_mode[63:32] == {4{$past(bus_wdata)}})
    else $error("quad broadcast incomplete");
  four_align_a: assert property (bus_wr && bus_addr == 18'h36219 && quad_rst_in == 8'h00
    |=> quad_four_align[2] == $past(bus_wdata[6]))
    else $error("align select bit misplaced");
  quad_reset_a: assert property (qrst_held |=> quad_mode[23:16] == 8'h00 && !quad_four_align[2])
    else $error("quad reset did not clear");
endmodule : pcs_regmap_properties

bind pcs_register_address_map pcs_regmap_properties pcs_regmap_properties_inst (.core_clk, .rst, .bus_addr,
  .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_ack, .cfg_we, .cfg_addr, .cfg_wdata, .align23_in,
  .ctc_urun_in, .ctc_orun_in, .quad_rst_in, .quad_mode, .quad_four_align, .interquad_ctl);
